// ### verilog/rbiv_ctrl.sv
// Reset sequencing, brown-out handling and interrupt vectoring controller
module rbiv_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rst_pin,
    input wire logic brownout_pin,
    input wire rbiv_pkg::rbiv_flags_t irq_flags,
    input wire logic irq_ack,
    input wire logic irq_return,
    input wire logic cpu_ale,
    input wire logic cpu_program_store_strobe_n,
    output logic cpu_reset_n,
    output logic [15:0] boot_addr,
    output logic irq_req,
    output logic [15:0] irq_vector,
    output logic ram_write_inhibit,
    output logic ale_out,
    output logic program_store_strobe_n,
    output logic powered_down
);
    import rbiv_pkg::*;

    // ==========================================
    // Pin synchronisers
    logic [1:0] rst_sync; // Stage 0 read only by stage 1
    logic [1:0] bod_sync; // Stage 0 read only by stage 1
    // Two flops per pin
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rst_sync <= 2'h0;
            bod_sync <= 2'h0;
        end
        else
        begin
            rst_sync <= {rst_sync[0], rst_pin};
            bod_sync <= {bod_sync[0], brownout_pin};
        end
    end

    // ==========================================
    // Reset sources
    logic [4:0] rst_cnt, next_rst_cnt; // Clocks of pin high
    logic [2:0] bod_cnt, next_bod_cnt; // Clocks below threshold
    logic [4:0] hold_cnt, next_hold_cnt; // Internal reset stretch
    rbiv_sfr_t sfr, next_sfr; // Special function bits
    logic pin_reset, bod_active, bod_reset, soft_fire, reset_now;
    logic wr_do; // Write committed this cycle
    logic [7:0] wr_addr; // Held write address
    logic [31:0] wr_data; // Held write data
    logic [3:0] wr_strb; // Held byte lanes

    assign pin_reset = rst_sync[1] && (rst_cnt == RST_MIN_CLOCKS);
    assign bod_active = (bod_cnt == BOD_FILTER_CLOCKS);
    assign bod_reset = bod_active && !sfr.brownout_irq_enable;
    assign soft_fire = wr_do && (wr_addr == FLASH_CONFIG_ADDR) && wr_strb[0]
        && wr_data[SOFT_RESET_BIT] && !sfr.soft_reset_bit
        && !reset_now; // Writes are dropped while reset is active
    assign reset_now = pin_reset || bod_reset || (hold_cnt != 5'h0);

    // Counters for pin, brown-out filter and stretch
    always_comb
    begin
        next_rst_cnt = 5'h0;
        if (rst_sync[1])
            next_rst_cnt = (rst_cnt == RST_MIN_CLOCKS) ? rst_cnt
                : rst_cnt + 5'h1;
        next_bod_cnt = 3'h0;
        if (bod_sync[1])
            next_bod_cnt = bod_active ? bod_cnt : bod_cnt + 3'h1;
        next_hold_cnt = (hold_cnt != 5'h0) ? hold_cnt - 5'h1 : 5'h0;
        if (soft_fire || bod_reset)
            next_hold_cnt = RST_MIN_CLOCKS;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rst_cnt <= 5'h0;
            bod_cnt <= 3'h0;
            hold_cnt <= 5'h0;
        end
        else
        begin
            rst_cnt <= next_rst_cnt;
            bod_cnt <= next_bod_cnt;
            hold_cnt <= next_hold_cnt;
        end
    end

    // ==========================================
    // Interrupt arbitration
    logic [9:0] raw, pend;
    logic [1:0] lvl [NUM_SRC];
    logic [3:0] act, next_act; // Levels in service
    logic [1:0] cur_lvl, best_lvl, req_lvl, next_req_lvl;
    logic [3:0] best_idx, req_idx, next_req_idx;
    logic found, next_irq_req;
    logic [15:0] next_irq_vector;

    assign raw = {irq_flags.timer2_overflow_flag
            | irq_flags.timer2_external_flag,
        irq_flags.serial_tx_rx_flags | irq_flags.sync_serial_done_flag,
        irq_flags.ext3_request_flag, irq_flags.ext2_request_flag,
        irq_flags.counter_array_flags, irq_flags.timer1_overflow_flag,
        irq_flags.ext1_request_flag, irq_flags.timer0_overflow_flag,
        1'b0, irq_flags.ext0_request_flag};

    // Per source enable, wake gating and level
    generate
        for (genvar i = 0; i < NUM_SRC; i++)
        begin : g_src
            if (i == BOD_SRC)
            begin : g_bod
                assign pend[i] = bod_active && sfr.brownout_irq_enable
                    && !sfr.powerdown_request_bit;
            end
            else
            begin : g_per
                assign pend[i] = raw[i] && sfr.irq_enable[i]
                    && (!sfr.powerdown_request_bit || WAKE_MASK[i]);
            end
            assign lvl[i] = {sfr.prio_hi[i], sfr.prio_lo[i]};
        end
    endgenerate

    // Highest level wins, lowest poll index breaks ties
    always_comb
    begin
        found = 1'b0;
        best_lvl = 2'h0;
        best_idx = 4'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (pend[i] && (!found || lvl[i] >= best_lvl))
            begin
                found = 1'b1;
                best_lvl = lvl[i];
                best_idx = 4'(i);
            end
        end
        cur_lvl = act[3] ? 2'h3 : act[2] ? 2'h2 : act[1] ? 2'h1 : 2'h0;
    end

    // Service bookkeeping and request
    always_comb
    begin
        next_act = act;
        if (irq_return)
            next_act[cur_lvl] = 1'b0;
        if (irq_ack && irq_req)
            next_act[req_lvl] = 1'b1;
        next_irq_req = found && (next_act == 4'h0 || best_lvl >
            (next_act[3] ? 2'h3 : next_act[2] ? 2'h2 :
            next_act[1] ? 2'h1 : 2'h0));
        next_req_lvl = best_lvl;
        next_req_idx = best_idx;
        next_irq_vector = VECTORS[best_idx];
        if (reset_now)
        begin
            next_act = 4'h0;
            next_irq_req = 1'b0;
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            act <= 4'h0;
            irq_req <= 1'b0;
            req_lvl <= 2'h0;
            req_idx <= 4'h0;
            irq_vector <= RESET_VECTOR;
        end
        else
        begin
            act <= next_act;
            irq_req <= next_irq_req;
            req_lvl <= next_req_lvl;
            req_idx <= next_req_idx;
            irq_vector <= next_irq_vector;
        end
    end

    // ==========================================
    // Register bus slave
    logic aw_held, w_held, next_aw_held, next_w_held;
    logic [7:0] next_wr_addr;
    logic [31:0] next_wr_data, next_rdata, rd_mux;
    logic [3:0] next_wr_strb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic wr_hit, rd_hit;

    // Lane merge for the two low bytes
    function automatic logic [9:0] merge10(logic [9:0] old, logic [31:0] d,
        logic [3:0] s);
        merge10 = {s[1] ? d[9:8] : old[9:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    assign wr_do = aw_held && w_held && !s_axi_bvalid;
    always_comb
    begin
        case (wr_addr)
            POWER_CONTROL_ADDR, FLASH_CONFIG_ADDR, WATCHDOG_CONTROL_ADDR,
            IRQ_ENABLE_ADDR, PRIO_LO_ADDR, PRIO_HI_ADDR, IRQ_STATUS_ADDR,
            AUX_IRQ_ENABLE_ADDR: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
        rd_hit = 1'b1;
        rd_mux = 32'h0;
        case (s_axi_araddr)
            POWER_CONTROL_ADDR: rd_mux = {27'h0, sfr.power_on_flag, 2'h0,
                sfr.powerdown_request_bit, sfr.idle_request_bit};
            FLASH_CONFIG_ADDR: rd_mux = {30'h0, sfr.soft_reset_bit, 1'b0};
            WATCHDOG_CONTROL_ADDR:
                rd_mux = {29'h0, sfr.watchdog_reset_status, 2'h0};
            IRQ_ENABLE_ADDR: rd_mux = {22'h0, sfr.irq_enable};
            PRIO_LO_ADDR: rd_mux = {22'h0, sfr.prio_lo};
            PRIO_HI_ADDR: rd_mux = {22'h0, sfr.prio_hi};
            IRQ_STATUS_ADDR: rd_mux = {10'h0, reset_now, bod_active, act,
                6'h0, pend};
            AUX_IRQ_ENABLE_ADDR:
                rd_mux = {28'h0, sfr.brownout_irq_enable, 3'h0};
            default: rd_hit = 1'b0;
        endcase
    end

    // Channel handshakes and answers
    always_comb
    begin
        next_aw_held = aw_held || (s_axi_awvalid && s_axi_awready);
        next_w_held = w_held || (s_axi_wvalid && s_axi_wready);
        next_wr_addr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr
            : wr_addr;
        next_wr_data = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wr_data;
        next_wr_strb = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wr_strb;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        if (wr_do)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_hit ? RESP_OKAY : RESP_DECERR;
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rdata = rd_mux;
            next_rresp = rd_hit ? RESP_OKAY : RESP_DECERR;
        end
        next_arready = !next_rvalid;
    end

    // Special function bits: writes, resets and wake
    always_comb
    begin
        next_sfr = sfr;
        if (wr_do && wr_strb[0])
        begin
            case (wr_addr)
                POWER_CONTROL_ADDR:
                begin
                    next_sfr.idle_request_bit = wr_data[IDLE_BIT];
                    next_sfr.powerdown_request_bit = wr_data[POWERDOWN_BIT];
                    next_sfr.power_on_flag = wr_data[POF_BIT];
                end
                FLASH_CONFIG_ADDR:
                    next_sfr.soft_reset_bit = wr_data[SOFT_RESET_BIT];
                WATCHDOG_CONTROL_ADDR:
                    next_sfr.watchdog_reset_status = wr_data[WATCHDOG_RESET_STATUS_BIT];
                AUX_IRQ_ENABLE_ADDR:
                    next_sfr.brownout_irq_enable = wr_data[EBO_BIT];
                default: ;
            endcase
        end
        if (wr_do && wr_addr == IRQ_ENABLE_ADDR)
            next_sfr.irq_enable = merge10(sfr.irq_enable, wr_data, wr_strb);
        if (wr_do && wr_addr == PRIO_LO_ADDR)
            next_sfr.prio_lo = merge10(sfr.prio_lo, wr_data, wr_strb);
        if (wr_do && wr_addr == PRIO_HI_ADDR)
            next_sfr.prio_hi = merge10(sfr.prio_hi, wr_data, wr_strb);
        if (irq_ack && irq_req)
        begin
            next_sfr.idle_request_bit = 1'b0;
            next_sfr.powerdown_request_bit = 1'b0;
        end
        if (reset_now)
        begin
            next_sfr = SFR_RESET;
            next_sfr.power_on_flag = sfr.power_on_flag;
            if (!pin_reset && !bod_reset)
            begin
                next_sfr.soft_reset_bit = sfr.soft_reset_bit;
                next_sfr.watchdog_reset_status = sfr.watchdog_reset_status;
            end
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= 8'h0;
            wr_data <= 32'h0;
            wr_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
            sfr <= SFR_RESET;
        end
        else
        begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            wr_strb <= next_wr_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            sfr <= next_sfr;
        end
    end

    // ==========================================
    // Core facing outputs, all registered
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cpu_reset_n <= 1'b0;
            boot_addr <= RESET_VECTOR;
            ram_write_inhibit <= 1'b1;
            ale_out <= 1'b1;
            program_store_strobe_n <= 1'b1;
            powered_down <= 1'b0;
        end
        else
        begin
            cpu_reset_n <= !reset_now;
            boot_addr <= RESET_VECTOR;
            ram_write_inhibit <= reset_now;
            ale_out <= reset_now || (cpu_ale
                && !sfr.powerdown_request_bit);
            program_store_strobe_n <= reset_now || (cpu_program_store_strobe_n
                && !sfr.powerdown_request_bit);
            powered_down <= sfr.powerdown_request_bit && !reset_now;
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence soft_start_s;
        soft_fire ##1 !pin_reset && !bod_reset;
    endsequence
    pin_accept_a: assert property (pin_reset |-> $past(rst_sync[1], 24))
        else $error("reset pin accepted too early");
    strobe_high_a: assert property (!cpu_reset_n |-> ale_out &&
        program_store_strobe_n) else $error("strobes low in reset");
    bod_filter_a: assert property ($rose(bod_active) |->
        $past(bod_sync[1], 4) && $past(bod_sync[1])) else $error("bod filter");
    bod_reset_a: assert property (bod_active && !sfr.brownout_irq_enable
        |=> !cpu_reset_n [*2]) else $error("brown-out did not reset");
    bod_run_a: assert property (bod_active && sfr.brownout_irq_enable &&
        !reset_now |=> cpu_reset_n) else $error("brown-out irq halted core");
    soft_edge_a: assert property (soft_fire |=>
        hold_cnt == RST_MIN_CLOCKS) else $error("soft reset not started");
    soft_keep_a: assert property (soft_start_s |->
        sfr.soft_reset_bit) else $error("soft bit lost in soft reset");
    pof_keep_a: assert property ($fell(sfr.power_on_flag) |->
        $past(wr_do && wr_addr == POWER_CONTROL_ADDR)) else $error("pof lost");
    preempt_a: assert property (irq_req && act != 4'h0 |->
        req_lvl > cur_lvl) else $error("request without higher level");
    wake_clr_a: assert property (irq_ack && irq_req && !reset_now |=>
        !sfr.powerdown_request_bit) else $error("power-down not cleared");
endmodule

// ### verilog/rbiv_pkg.sv
// Constants, register map and carrier types of the reset and vectoring block
// Functional notes
// - Execution restarts at address 0000H after reset
// - Address strobe and store strobe high during reset
// - Reset leaves on-chip data RAM untouched
// - Every special register but the power-on flag reloads reset value; soft reset also keeps soft bit and watchdog status
// - Power-on flag set at power-up, software clears
// - Soft reset only on soft bit rising
// - Soft reset keeps soft bit and watchdog status
// - Brown-out needs four consecutive low clocks
// - Brown-out without interrupt enable resets processor
// - Brown-out with enable bit vectors to 004BH
// - Brown-out interrupt keeps processor running
// - Clearing enable during brown-out forces reset
// - Four priority levels, two bits per source
// - Fixed polling order within one level
// - Both serial units share vector 0023H
// - Power-down wakes only by external 0 or 1
package rbiv_pkg;
    // ==========================================
    // Timing
    localparam int MACHINE_CYCLE_CLOCKS = 12; // Oscillator clocks per cycle
    localparam int RST_MIN_CYCLES = 2; // Machine cycles of reset pin
    localparam logic [4:0] RST_MIN_CLOCKS =
        5'(MACHINE_CYCLE_CLOCKS * RST_MIN_CYCLES);
    localparam logic [2:0] BOD_FILTER_CLOCKS = 3'h4; // Brown-out filter
    // ==========================================
    // Register byte addresses
    localparam logic [7:0] POWER_CONTROL_ADDR = 8'h00;
    localparam logic [7:0] FLASH_CONFIG_ADDR = 8'h04;
    localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'h08;
    localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h0c;
    localparam logic [7:0] PRIO_LO_ADDR = 8'h10;
    localparam logic [7:0] PRIO_HI_ADDR = 8'h14;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'h18;
    localparam logic [7:0] AUX_IRQ_ENABLE_ADDR = 8'he8;
    // ==========================================
    // Field positions
    localparam int IDLE_BIT = 0;
    localparam int POWERDOWN_BIT = 1;
    localparam int POF_BIT = 4;
    localparam int SOFT_RESET_BIT = 1;
    localparam int WATCHDOG_RESET_STATUS_BIT = 2;
    localparam int EBO_BIT = 3;
    localparam int NUM_SRC = 10; // Sources in polling order
    localparam int BOD_SRC = 1; // Brown-out slot
    localparam logic [9:0] WAKE_MASK = 10'h009; // External 0 and 1
    // ==========================================
    // Vectors
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] VECTORS [NUM_SRC] = '{16'h0003, 16'h004b,
        16'h000b, 16'h0013, 16'h001b, 16'h0033, 16'h003b, 16'h0043,
        16'h0023, 16'h002b};
    // ==========================================
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Peripheral request flags
    typedef struct packed {
        logic timer2_external_flag;
        logic timer2_overflow_flag;
        logic sync_serial_done_flag;
        logic serial_tx_rx_flags;
        logic ext3_request_flag;
        logic ext2_request_flag;
        logic counter_array_flags;
        logic timer1_overflow_flag;
        logic ext1_request_flag;
        logic timer0_overflow_flag;
        logic ext0_request_flag;
    } rbiv_flags_t;
    // Special function bits held by the block
    typedef struct packed {
        logic idle_request_bit;
        logic powerdown_request_bit;
        logic power_on_flag;
        logic soft_reset_bit;
        logic watchdog_reset_status;
        logic brownout_irq_enable;
        logic [9:0] irq_enable;
        logic [9:0] prio_lo;
        logic [9:0] prio_hi;
    } rbiv_sfr_t;
    localparam rbiv_sfr_t SFR_RESET = '{power_on_flag: 1'b1, default: '0};
endpackage

// ### sim/rbiv_supply_model.sv
// Model of the external reset circuit and the supply monitor
module rbiv_supply_model (
    input wire logic aclk,
    input wire logic rst_go,
    input wire logic [7:0] rst_len,
    input wire logic bod_go,
    input wire logic [7:0] bod_len,
    output logic rst_pin,
    output logic brownout_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rst_cnt = 8'h00; // Clocks of pin pulse left
    logic [7:0] bod_cnt = 8'h00; // Clocks of supply dip left
    // Load a request, then count it down one clock at a time
    always @(posedge aclk)
    begin
        if (rst_go)
            rst_cnt <= rst_len;
        else if (rst_cnt != 8'h00)
            rst_cnt <= rst_cnt - 8'h01;
        if (bod_go)
            bod_cnt <= bod_len;
        else if (bod_cnt != 8'h00)
            bod_cnt <= bod_cnt - 8'h01;
    end
    assign rst_pin = rst_cnt != 8'h00; // Pin high while counting
    assign brownout_pin = bod_cnt != 8'h00; // Supply low while counting
endmodule

// ### sim/tb_reset_brownout_irq_vectoring.sv
// Self-checking bench of the reset and vectoring block
module tb_reset_brownout_irq_vectoring;
    timeunit 1ns;
    timeprecision 1ps;
    import rbiv_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, rst_len = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [1:0] bresp, rresp;
    logic rst_go = 1'b0, bod_go = 1'b0, rst_pin, brownout_pin, hit;
    logic [7:0] bod_len = 8'h00;
    logic [3:0] wstrb = 4'hf; // Write byte lanes
    rbiv_flags_t flg = '0; // Peripheral request flags
    logic irq_ack = 1'b0, irq_return = 1'b0, cpu_ale = 1'b0, cpu_psn = 1'b0;
    logic cpu_reset_n, irq_req, ram_write_inhibit, ale_out, psn, pdn;
    logic [15:0] boot_addr, irq_vector;
    int num_errors = 0, compares = 0;
    always #2 aclk = ~aclk;
    rbiv_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rst_pin(rst_pin),
        .brownout_pin(brownout_pin), .irq_flags(flg), .irq_ack(irq_ack),
        .irq_return(irq_return), .cpu_ale(cpu_ale),
        .cpu_program_store_strobe_n(cpu_psn), .cpu_reset_n(cpu_reset_n),
        .boot_addr(boot_addr), .irq_req(irq_req), .irq_vector(irq_vector),
        .ram_write_inhibit(ram_write_inhibit), .ale_out(ale_out),
        .program_store_strobe_n(psn), .powered_down(pdn));
    rbiv_supply_model sup_u (.aclk(aclk), .rst_go(rst_go),
        .rst_len(rst_len), .bod_go(bod_go), .bod_len(bod_len),
        .rst_pin(rst_pin), .brownout_pin(brownout_pin));
    // ==========================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] got, exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Write one word, both channels offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!(awready && wready) && (awvalid || wvalid));
        while (bvalid !== 1'b1)
            @(posedge aclk);
        bready <= 1'b0;
    endtask
    // Read one word into rd
    task automatic rdw(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd = rdata;
        rready <= 1'b0;
    endtask
    // Watch core reset (sel 0) or request (sel 1) for a level
    task automatic wt(input bit sel, input logic v, input int n);
        hit = 1'b0;
        repeat (n)
        begin
            @(posedge aclk);
            if ((sel ? irq_req : cpu_reset_n) === v)
            begin
                hit = 1'b1;
                break;
            end
        end
    endtask
    task automatic finish_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_pin();
        rdw(8'h00);
        chk("pof_reset", rd, 32'h10);
        rdw(8'h30);
        chk("unmapped", {30'h0, rresp}, {30'h0, RESP_DECERR});
        wr(8'h30, 32'h1);
        chk("wr_unmapped", {30'h0, bresp}, {30'h0, RESP_DECERR});
        rst_len <= 8'd10;
        rst_go <= 1'b1;
        @(posedge aclk) rst_go <= 1'b0;
        wt(0, 1'b0, 40);
        chk("short_pin", hit, 1'b0);
        rst_len <= 8'd30;
        rst_go <= 1'b1;
        @(posedge aclk) rst_go <= 1'b0;
        wt(0, 1'b0, 50);
        chk("long_pin", hit, 1'b1);
        chk("strobes", {ale_out, psn, ram_write_inhibit}, 3'h7);
        chk("boot", boot_addr, RESET_VECTOR);
        wt(0, 1'b1, 60);
        chk("pin_release", hit, 1'b1);
        chk("ram_free", ram_write_inhibit, 1'b0);
        rdw(8'h00);
        chk("pof_kept", rd, 32'h10);
        wr(8'h00, 32'h0);
        rdw(8'h00);
        chk("pof_clr", rd, 32'h0);
    endtask
    task automatic t_soft();
        wr(8'h0c, 32'h3ff);
        wr(8'h08, 32'h4);
        wr(8'h04, 32'h2);
        wt(0, 1'b0, 20);
        chk("soft_go", hit, 1'b1);
        wt(0, 1'b1, 60);
        chk("soft_release", hit, 1'b1);
        rdw(8'h04);
        chk("soft_bit", rd, 32'h2);
        rdw(8'h08);
        chk("wd_stat", rd, 32'h4);
        rdw(8'h0c);
        chk("ien_reload", rd, 32'h0);
        wstrb <= 4'h1;
        wr(8'h0c, 32'h3ff);
        wstrb <= 4'hf;
        rdw(8'h0c);
        chk("low_lane", rd, 32'hff);
        wr(8'h04, 32'h2);
        wt(0, 1'b0, 40);
        chk("soft_level", hit, 1'b0);
    endtask
    task automatic dip(input logic [7:0] n);
        bod_len <= n;
        bod_go <= 1'b1;
        @(posedge aclk) bod_go <= 1'b0;
    endtask
    task automatic t_bod();
        dip(8'd3);
        wt(0, 1'b0, 30);
        chk("bod_short", hit, 1'b0);
        dip(8'd40);
        wt(0, 1'b0, 30);
        chk("bod_reset", hit, 1'b1);
        wt(0, 1'b1, 120);
        chk("bod_release", hit, 1'b1);
        wr(8'he8, 32'h8);
        dip(8'd60);
        wt(1, 1'b1, 20);
        chk("bod_vec", irq_vector, 16'h004b);
        chk("bod_run", cpu_reset_n, 1'b1);
        wr(8'he8, 32'h0);
        wt(0, 1'b0, 20);
        chk("ebo_clear", hit, 1'b1);
        wt(0, 1'b1, 150);
        chk("ebo_release", hit, 1'b1);
    endtask
    task automatic t_irq();
        wr(8'h0c, 32'h3ff);
        flg.timer2_overflow_flag <= 1'b1;
        flg.sync_serial_done_flag <= 1'b1;
        flg.ext3_request_flag <= 1'b1;
        wt(1, 1'b1, 10);
        chk("poll", irq_vector, 16'h0043);
        flg.ext3_request_flag <= 1'b0;
        repeat (4) @(posedge aclk);
        chk("serial", irq_vector, 16'h0023);
        flg.ext0_request_flag <= 1'b1;
        wr(8'h14, 32'h200);
        repeat (4) @(posedge aclk);
        chk("level", irq_vector, 16'h002b);
        irq_ack <= 1'b1;
        @(posedge aclk) irq_ack <= 1'b0;
        repeat (4) @(posedge aclk);
        chk("no_preempt", irq_req, 1'b0);
        irq_return <= 1'b1;
        @(posedge aclk) irq_return <= 1'b0;
        wt(1, 1'b1, 10);
        chk("after_ret", irq_vector, 16'h002b);
        flg <= '0;
        wr(8'h00, 32'h2);
        @(posedge aclk);
        chk("pd_on", pdn, 1'b1);
        flg.timer0_overflow_flag <= 1'b1;
        cpu_ale <= 1'b1;
        cpu_psn <= 1'b1;
        wt(1, 1'b1, 6);
        chk("pd_t0", hit, 1'b0);
        chk("pd_strobes", {ale_out, psn}, 2'h0);
        flg.ext1_request_flag <= 1'b1;
        wt(1, 1'b1, 10);
        chk("pd_wake", irq_vector, 16'h0013);
        irq_ack <= 1'b1;
        @(posedge aclk) irq_ack <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("pd_off", pdn, 1'b0);
        chk("run_strobes", {ale_out, psn}, 2'h3);
        wr(8'h10, 32'h1);
        flg.ext0_request_flag <= 1'b1;
        wt(1, 1'b1, 10);
        chk("preempt_req", hit, 1'b1);
        chk("preempt_vec", irq_vector, 16'h0003);
    endtask
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        t_pin();
        t_soft();
        t_bod();
        t_irq();
        finish_test();
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        finish_test();
    end
endmodule
